// ---- core/accr_regs.sv ----
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module accr_regs (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire accr_pkg::accr_req_t reg_req,
  output var  logic [15:0]         reg_rdata,
  output var  logic signed [23:0]  chan1_offset_low_out,
  output var  logic [23:0]         chan1_gain,
  output var  logic signed [23:0]  chan2_offset,
  output var  logic [23:0]         chan2_gain_high_out,
  output var  accr_pkg::accr_setup_t chan2_setup
);

  // Stored fields; reserved bits have no storage at all.
  logic [7:0]  chan1_offset_low_byte_q, chan1_offset_low_byte_d;
  logic [15:0] chan1_gain_high_word_q, chan1_gain_high_word_d;
  logic [7:0]  chan1_gain_low_byte_q, chan1_gain_low_byte_d;
  logic [9:0]  chan2_phase_delay_q, chan2_phase_delay_d;
  logic        temp_sensor_source_q, temp_sensor_source_d;
  logic        temp_sensor_enable_q, temp_sensor_enable_d;
  logic        temp_sensor_invert_q, temp_sensor_invert_d;
  logic [1:0]  chan2_input_select_q, chan2_input_select_d;
  logic [15:0] chan2_offset_high_word_q, chan2_offset_high_word_d;
  logic [7:0]  chan2_offset_low_byte_q, chan2_offset_low_byte_d;
  logic [15:0] chan2_gain_high_word_q, chan2_gain_high_word_d;
  logic [15:0] rdata_q, rdata_d;

  // Write decode; only implemented fields take the write data.
  always_comb begin
    chan1_offset_low_byte_d = chan1_offset_low_byte_q;
    chan1_gain_high_word_d = chan1_gain_high_word_q;
    chan1_gain_low_byte_d = chan1_gain_low_byte_q;
    chan2_phase_delay_d = chan2_phase_delay_q;
    temp_sensor_source_d = temp_sensor_source_q;
    temp_sensor_enable_d = temp_sensor_enable_q;
    temp_sensor_invert_d = temp_sensor_invert_q;
    chan2_input_select_d = chan2_input_select_q;
    chan2_offset_high_word_d = chan2_offset_high_word_q;
    chan2_offset_low_byte_d = chan2_offset_low_byte_q;
    chan2_gain_high_word_d = chan2_gain_high_word_q;
    if (reg_req.wr) begin
      if (reg_req.addr == accr_pkg::ADDR_C1_OFS_LO) begin
        chan1_offset_low_byte_d = reg_req.wdata[15:8];
      end else if (reg_req.addr == accr_pkg::ADDR_C1_GAIN_HI) begin
        chan1_gain_high_word_d = reg_req.wdata;
      end else if (reg_req.addr == accr_pkg::ADDR_C1_GAIN_LO) begin
        chan1_gain_low_byte_d = reg_req.wdata[15:8];
      end else if (reg_req.addr == accr_pkg::ADDR_C2_SETUP) begin
        chan2_phase_delay_d = reg_req.wdata[accr_pkg::PHASE_MSB:accr_pkg::PHASE_LSB];
        temp_sensor_source_d = reg_req.wdata[accr_pkg::TS_SRC_BIT];
        temp_sensor_enable_d = reg_req.wdata[accr_pkg::TEMP_EN_BIT];
        temp_sensor_invert_d = reg_req.wdata[accr_pkg::TS_INV_BIT];
        chan2_input_select_d = reg_req.wdata[accr_pkg::MUX_MSB:accr_pkg::MUX_LSB];
      end else if (reg_req.addr == accr_pkg::ADDR_C2_OFS_HI) begin
        chan2_offset_high_word_d = reg_req.wdata;
      end else if (reg_req.addr == accr_pkg::ADDR_C2_OFS_LO) begin
        chan2_offset_low_byte_d = reg_req.wdata[15:8];
      end else if (reg_req.addr == accr_pkg::ADDR_C2_GAIN_HI) begin
        chan2_gain_high_word_d = reg_req.wdata;
      end
    end
  end

  // Read decode; reserved bits and unmapped addresses return zero.
  always_comb begin
    rdata_d = accr_pkg::RST_ZERO;
    if (reg_req.rd) begin
      if (reg_req.addr == accr_pkg::ADDR_C1_OFS_LO) begin
        rdata_d = {chan1_offset_low_byte_q, accr_pkg::RST_BYTE};
      end else if (reg_req.addr == accr_pkg::ADDR_C1_GAIN_HI) begin
        rdata_d = chan1_gain_high_word_q;
      end else if (reg_req.addr == accr_pkg::ADDR_C1_GAIN_LO) begin
        rdata_d = {chan1_gain_low_byte_q, accr_pkg::RST_BYTE};
      end else if (reg_req.addr == accr_pkg::ADDR_C2_SETUP) begin
        rdata_d = {chan2_phase_delay_q, temp_sensor_source_q, temp_sensor_enable_q,
                   1'b0, temp_sensor_invert_q, chan2_input_select_q};
      end else if (reg_req.addr == accr_pkg::ADDR_C2_OFS_HI) begin
        rdata_d = chan2_offset_high_word_q;
      end else if (reg_req.addr == accr_pkg::ADDR_C2_OFS_LO) begin
        rdata_d = {chan2_offset_low_byte_q, accr_pkg::RST_BYTE};
      end else if (reg_req.addr == accr_pkg::ADDR_C2_GAIN_HI) begin
        rdata_d = chan2_gain_high_word_q;
      end
    end
  end

  // Register stage with documented reset values.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      chan1_offset_low_byte_q <= accr_pkg::RST_BYTE;
      chan1_gain_high_word_q <= accr_pkg::RST_GAIN_HI;
      chan1_gain_low_byte_q <= accr_pkg::RST_BYTE;
      chan2_phase_delay_q <= accr_pkg::RST_SETUP[15:6];
      temp_sensor_source_q <= accr_pkg::RST_SETUP[accr_pkg::TS_SRC_BIT];
      temp_sensor_enable_q <= accr_pkg::RST_SETUP[accr_pkg::TEMP_EN_BIT];
      temp_sensor_invert_q <= accr_pkg::RST_SETUP[accr_pkg::TS_INV_BIT];
      chan2_input_select_q <= accr_pkg::RST_SETUP[accr_pkg::MUX_MSB:accr_pkg::MUX_LSB];
      chan2_offset_high_word_q <= accr_pkg::RST_ZERO;
      chan2_offset_low_byte_q <= accr_pkg::RST_BYTE;
      chan2_gain_high_word_q <= accr_pkg::RST_GAIN_HI;
      rdata_q <= accr_pkg::RST_ZERO;
    end else begin
      chan1_offset_low_byte_q <= chan1_offset_low_byte_d;
      chan1_gain_high_word_q <= chan1_gain_high_word_d;
      chan1_gain_low_byte_q <= chan1_gain_low_byte_d;
      chan2_phase_delay_q <= chan2_phase_delay_d;
      temp_sensor_source_q <= temp_sensor_source_d;
      temp_sensor_enable_q <= temp_sensor_enable_d;
      temp_sensor_invert_q <= temp_sensor_invert_d;
      chan2_input_select_q <= chan2_input_select_d;
      chan2_offset_high_word_q <= chan2_offset_high_word_d;
      chan2_offset_low_byte_q <= chan2_offset_low_byte_d;
      chan2_gain_high_word_q <= chan2_gain_high_word_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs come straight from flip-flops; words are concatenations of fields.
  assign reg_rdata = rdata_q;
  assign chan1_offset_low_out = {16'h0000, chan1_offset_low_byte_q};
  assign chan1_gain = {chan1_gain_high_word_q, chan1_gain_low_byte_q};
  assign chan2_offset = {chan2_offset_high_word_q, chan2_offset_low_byte_q};
  assign chan2_gain_high_out = {chan2_gain_high_word_q, 8'h00};
  assign chan2_setup = '{phase: chan2_phase_delay_q, ts_external: temp_sensor_source_q,
                         ts_enable: temp_sensor_enable_q, ts_invert: temp_sensor_invert_q,
                         input_sel: accr_pkg::accr_in_sel_t'(chan2_input_select_q)};

  // High when the bus address falls inside the mapped register window.
  logic addr_mapped;
  assign addr_mapped = (reg_req.addr >= accr_pkg::ADDR_C1_OFS_LO) &&
                       (reg_req.addr <= accr_pkg::ADDR_C2_GAIN_HI);

  // A write strobe aimed at one register address.
  sequence wr_at_s(logic [5:0] a);
    reg_req.wr && reg_req.addr == a;
  endsequence

  // A read strobe aimed at one register address.
  sequence rd_at_s(logic [5:0] a);
    reg_req.rd && reg_req.addr == a;
  endsequence

  // Gain high registers come out of reset at unity.
  gain_reset_a: assert property (
    @(posedge core_clk) $fell(rst) |->
    chan1_gain[23:8] == 16'h8000 && chan2_gain_high_out[23:8] == 16'h8000)
    else $error("gain high not unity after reset");

  // Setup register clears on reset.
  setup_reset_a: assert property (
    @(posedge core_clk) $fell(rst) |->
    chan2_setup == '0)
    else $error("setup not zero after reset");

  // A write to gain high appears on the gain word next cycle.
  gain1_write_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_at_s(accr_pkg::ADDR_C1_GAIN_HI) |=> chan1_gain[23:8] == $past(reg_req.wdata))
    else $error("chan1 gain high write lost");

  // Low byte of offset comes from data bits 15:8.
  ofs2_low_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_at_s(accr_pkg::ADDR_C2_OFS_LO) |=> chan2_offset[7:0] == $past(reg_req.wdata[15:8]))
    else $error("chan2 offset low byte wrong");

  // Offset high word lands in bits 23:8.
  ofs2_high_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_at_s(accr_pkg::ADDR_C2_OFS_HI) |=> chan2_offset[23:8] == $past(reg_req.wdata))
    else $error("chan2 offset high word wrong");

  // Setup read returns the reserved bit 3 as zero.
  setup_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd_at_s(accr_pkg::ADDR_C2_SETUP) |=> reg_rdata[3] == 1'b0)
    else $error("reserved setup bit reads one");

  // Channel 1 low registers read zero in their lower byte.
  low_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    reg_req.rd && (reg_req.addr == 6'h10 || reg_req.addr == 6'h12) |=> reg_rdata[7:0] == 8'h00)
    else $error("reserved low byte reads nonzero");

  // Input select and phase take their bits of a setup write.
  mux_write_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_at_s(accr_pkg::ADDR_C2_SETUP) |=> chan2_setup.input_sel == $past(reg_req.wdata[1:0]) &&
    chan2_setup.phase == $past(reg_req.wdata[15:6]))
    else $error("setup write fields wrong");

  // Offsets come out of reset at zero.
  ofs_reset_a: assert property (
    @(posedge core_clk) $fell(rst) |->
    chan2_offset == 24'h000000 && chan1_offset_low_out == 24'h000000)
    else $error("offset not zero after reset");

  // Channel 1 gain low byte comes out of reset at zero.
  gain_low_reset_a: assert property (
    @(posedge core_clk) $fell(rst) |->
    chan1_gain[7:0] == 8'h00)
    else $error("gain low byte not zero after reset");

  // Channel 1 gain low byte takes data bits 15:8.
  gain1_low_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_at_s(accr_pkg::ADDR_C1_GAIN_LO) |=> chan1_gain[7:0] == $past(reg_req.wdata[15:8]))
    else $error("chan1 gain low byte wrong");

  // Channel 1 offset low byte takes data bits 15:8.
  ofs1_low_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_at_s(accr_pkg::ADDR_C1_OFS_LO) |=> chan1_offset_low_out[7:0] == $past(reg_req.wdata[15:8]))
    else $error("chan1 offset low byte wrong");

  // Channel 2 gain high word lands in bits 23:8.
  gain2_high_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_at_s(accr_pkg::ADDR_C2_GAIN_HI) |=> chan2_gain_high_out[23:8] == $past(reg_req.wdata))
    else $error("chan2 gain high write lost");

  // Temperature sensor source follows setup bit 5.
  ts_source_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_at_s(accr_pkg::ADDR_C2_SETUP) |=> chan2_setup.ts_external == $past(reg_req.wdata[5]))
    else $error("sensor source bit wrong");

  // Temperature sensor enable follows setup bit 4.
  ts_enable_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_at_s(accr_pkg::ADDR_C2_SETUP) |=> chan2_setup.ts_enable == $past(reg_req.wdata[4]))
    else $error("sensor enable bit wrong");

  // Temperature sensor inversion follows setup bit 2.
  ts_invert_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_at_s(accr_pkg::ADDR_C2_SETUP) |=> chan2_setup.ts_invert == $past(reg_req.wdata[2]))
    else $error("sensor invert bit wrong");

  // Channel 1 gain high word only changes on its own write.
  gain1_hold_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !(reg_req.wr && reg_req.addr == accr_pkg::ADDR_C1_GAIN_HI) |=> $stable(chan1_gain[23:8]))
    else $error("chan1 gain high changed without write");

  // Channel 2 gain high word only changes on its own write.
  gain2_hold_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !(reg_req.wr && reg_req.addr == accr_pkg::ADDR_C2_GAIN_HI) |=> $stable(chan2_gain_high_out))
    else $error("chan2 gain high changed without write");

  // Channel 2 offset high word only changes on its own write.
  ofs2_hold_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !(reg_req.wr && reg_req.addr == accr_pkg::ADDR_C2_OFS_HI) |=> $stable(chan2_offset[23:8]))
    else $error("chan2 offset high changed without write");

  // Setup fields only change on a setup write.
  setup_hold_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !(reg_req.wr && reg_req.addr == accr_pkg::ADDR_C2_SETUP) |=> $stable(chan2_setup))
    else $error("setup changed without write");

  // Channel 1 offset low byte only changes on its own write.
  ofs1_hold_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !(reg_req.wr && reg_req.addr == accr_pkg::ADDR_C1_OFS_LO) |=> $stable(chan1_offset_low_out))
    else $error("chan1 offset low changed without write");

  // Channel 1 gain high reads back the stored word.
  gain1_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd_at_s(accr_pkg::ADDR_C1_GAIN_HI) |=> reg_rdata == $past(chan1_gain[23:8]))
    else $error("chan1 gain high read wrong");

  // Channel 1 gain low reads back its byte in bits 15:8.
  gain1_low_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd_at_s(accr_pkg::ADDR_C1_GAIN_LO) |=> reg_rdata == {$past(chan1_gain[7:0]), 8'h00})
    else $error("chan1 gain low read wrong");

  // Channel 1 offset low reads back its byte in bits 15:8.
  ofs1_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd_at_s(accr_pkg::ADDR_C1_OFS_LO) |=> reg_rdata == {$past(chan1_offset_low_out[7:0]), 8'h00})
    else $error("chan1 offset low read wrong");

  // Setup read returns the phase delay in bits 15:6.
  phase_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd_at_s(accr_pkg::ADDR_C2_SETUP) |=> reg_rdata[15:6] == $past(chan2_setup.phase))
    else $error("phase read wrong");

  // Setup read returns the sensor flags in bits 5, 4 and 2.
  ts_flags_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd_at_s(accr_pkg::ADDR_C2_SETUP) |=>
    reg_rdata[5:4] == {$past(chan2_setup.ts_external), $past(chan2_setup.ts_enable)} &&
    reg_rdata[2] == $past(chan2_setup.ts_invert))
    else $error("sensor flags read wrong");

  // Channel 2 offset high reads back the stored word.
  ofs2_high_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd_at_s(accr_pkg::ADDR_C2_OFS_HI) |=> reg_rdata == $past(chan2_offset[23:8]))
    else $error("chan2 offset high read wrong");

  // Channel 2 offset low reads back its byte in bits 15:8.
  ofs2_low_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd_at_s(accr_pkg::ADDR_C2_OFS_LO) |=> reg_rdata == {$past(chan2_offset[7:0]), 8'h00})
    else $error("chan2 offset low read wrong");

  // Channel 2 gain high reads back the stored word.
  gain2_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd_at_s(accr_pkg::ADDR_C2_GAIN_HI) |=> reg_rdata == $past(chan2_gain_high_out[23:8]))
    else $error("chan2 gain high read wrong");

  // Read data is zero in every cycle that no read answers.
  rdata_idle_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !reg_req.rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero when idle");

  // Reads outside the mapped window return zero.
  unmapped_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    reg_req.rd && !addr_mapped |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");

  // Writes outside the mapped window change nothing.
  unmapped_write_a: assert property (
    @(posedge core_clk) disable iff (rst)
    reg_req.wr && !addr_mapped |=> $stable(chan1_gain) && $stable(chan2_offset) &&
    $stable(chan2_setup) && $stable(chan1_offset_low_out) && $stable(chan2_gain_high_out))
    else $error("unmapped write changed a field");

  // Halves held elsewhere show as zero in the joined words.
  zero_fill_a: assert property (
    @(posedge core_clk)
    chan1_offset_low_out[23:8] == 16'h0000 && chan2_gain_high_out[7:0] == 8'h00)
    else $error("zero fill of joined word broken");

endmodule
`default_nettype wire

// ---- core/accr_pkg.sv ----
`default_nettype none
package accr_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 16;

  // Register addresses.
  localparam logic [5:0] ADDR_C1_OFS_LO = 6'h10;
  localparam logic [5:0] ADDR_C1_GAIN_HI = 6'h11;
  localparam logic [5:0] ADDR_C1_GAIN_LO = 6'h12;
  localparam logic [5:0] ADDR_C2_SETUP = 6'h13;
  localparam logic [5:0] ADDR_C2_OFS_HI = 6'h14;
  localparam logic [5:0] ADDR_C2_OFS_LO = 6'h15;
  localparam logic [5:0] ADDR_C2_GAIN_HI = 6'h16;

  // Reset values.
  localparam logic [15:0] RST_GAIN_HI = 16'h8000;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_SETUP = 16'h0000;

  // Field positions of the channel 2 setup register, and the low byte position of the low registers.
  localparam int unsigned PHASE_LSB = 6;
  localparam int unsigned PHASE_MSB = 15;
  localparam int unsigned TS_SRC_BIT = 5;
  localparam int unsigned TEMP_EN_BIT = 4;
  localparam int unsigned TS_INV_BIT = 2;
  localparam int unsigned MUX_LSB = 0;
  localparam int unsigned MUX_MSB = 1;
  localparam int unsigned LOWBYTE_LSB = 8;

  // Channel input selection codes.
  typedef enum logic [1:0] {
    ACCR_IN_NORMAL = 2'h0,
    ACCR_IN_SHORT = 2'h1,
    ACCR_IN_DC_DIAG = 2'h2,
    ACCR_IN_AC_DIAG = 2'h3
  } accr_in_sel_t;

  // Channel 2 setup fields as seen by the datapath.
  typedef struct packed {
    logic signed [9:0] phase;
    logic              ts_external;
    logic              ts_enable;
    logic              ts_invert;
    accr_in_sel_t      input_sel;
  } accr_setup_t;

  // Register port request.
  typedef struct packed {
    logic [5:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } accr_req_t;

endpackage
`default_nettype wire

// ---- dv/accr_regs_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module accr_regs_test;
  logic                  core_clk = 1'b0;
  logic                  rst = 1'b1;
  accr_pkg::accr_req_t   reg_req = '0;
  logic [15:0]           reg_rdata;
  logic signed [23:0]    c1_ofs;
  logic [23:0]           c1_gain;
  logic signed [23:0]    c2_ofs;
  logic [23:0]           c2_gain;
  accr_pkg::accr_setup_t c2_setup;
  int                    bad_count = 0;
  int                    n_compared = 0;

  // The clock toggles every half period of 25 ns.
  always #25 core_clk = ~core_clk;

  // The register bank under test.
  accr_regs i_accr_regs (
    .core_clk            (core_clk),
    .rst                 (rst),
    .reg_req             (reg_req),
    .reg_rdata           (reg_rdata),
    .chan1_offset_low_out(c1_ofs),
    .chan1_gain          (c1_gain),
    .chan2_offset        (c2_ofs),
    .chan2_gain_high_out (c2_gain),
    .chan2_setup         (c2_setup)
  );

  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Issues one strobe cycle, then idles and lets the result settle.
  task automatic bus(input logic [5:0] a, input logic [15:0] d, input logic w);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge core_clk);
    reg_req <= '0;
    #1;
  endtask

  // Reads one register and checks the data of the following cycle.
  task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
    bus(a, 16'h0000, 1'b0);
    chk(24'(reg_rdata), 24'(exp));
  endtask

  // Checks every reset value through the port and at the outputs.
  task automatic test_reset();
    rd_chk(6'h10, 16'h0000);
    rd_chk(6'h11, 16'h8000);
    rd_chk(6'h12, 16'h0000);
    rd_chk(6'h13, 16'h0000);
    rd_chk(6'h14, 16'h0000);
    rd_chk(6'h15, 16'h0000);
    rd_chk(6'h16, 16'h8000);
    chk(c1_gain, 24'h800000);
    chk(24'(c2_setup), 24'h000000);
    chk(c2_gain, 24'h800000);
    chk(c2_ofs, 24'h000000);
    chk(c1_ofs, 24'h000000);
    $display("test reset done");
  endtask

  // Writes channel 1 gain halves and checks the joined word.
  task automatic test_gain();
    bus(6'h11, 16'hA5C3, 1'b1);
    bus(6'h12, 16'h7EFF, 1'b1);
    rd_chk(6'h11, 16'hA5C3);
    @(posedge core_clk);
    #1;
    chk(24'(reg_rdata), 24'h000000);
    rd_chk(6'h12, 16'h7E00);
    chk(c1_gain, 24'hA5C37E);
    bus(6'h16, 16'h1234, 1'b1);
    rd_chk(6'h16, 16'h1234);
    chk(c2_gain, 24'h123400);
    $display("test gain done");
  endtask

  // Walks every input code with phase extremes and toggled flags.
  task automatic test_setup();
    logic [15:0] w;
    for (int i = 0; i < 4; i++) begin
      w = i[0] ? 16'h803C : 16'h7FC8;
      w[1:0] = i[1:0];
      bus(6'h13, w, 1'b1);
      rd_chk(6'h13, w & 16'hFFF7);
      chk(24'(c2_setup), 24'({w[15:6], w[5], w[4], w[2], w[1:0]}));
    end
    $display("test setup done");
  endtask

  // Offsets, reserved low bytes and an unmapped address.
  task automatic test_offset();
    bus(6'h14, 16'h8001, 1'b1);
    bus(6'h15, 16'hFF12, 1'b1);
    rd_chk(6'h14, 16'h8001);
    rd_chk(6'h15, 16'hFF00);
    chk(c2_ofs, 24'h8001FF);
    bus(6'h10, 16'hABCD, 1'b1);
    rd_chk(6'h10, 16'hAB00);
    chk(c1_ofs, 24'h0000AB);
    bus(6'h3F, 16'hFFFF, 1'b1);
    rd_chk(6'h3F, 16'h0000);
    rd_chk(6'h10, 16'hAB00);
    $display("test offset done");
  endtask

  // Pulses reset in mid-run and checks that every field returns to its reset value.
  task automatic test_mid_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(c1_gain, 24'h800000);
    chk(c2_gain, 24'h800000);
    chk(c2_ofs, 24'h000000);
    chk(c1_ofs, 24'h000000);
    chk(24'(c2_setup), 24'h000000);
    rd_chk(6'h16, 16'h8000);
    $display("test mid reset done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Cuts a hang short well after the tests should have ended.
  initial begin
    repeat (3000) @(posedge core_clk);
    bad_count++;
    $display("BAD at %0t: watchdog expired", $time);
    give_verdict();
  end

  // Holds reset for eight cycles, then runs every test in turn.
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    test_reset();
    test_gain();
    test_setup();
    test_offset();
    test_mid_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
